// ===== hdl/power_mgmt_control_status_defs.svh
// offsets, field positions, reset values and timing counts of the power csr block
`ifndef POWER_MGMT_CONTROL_STATUS_DEFS_SVH
`define POWER_MGMT_CONTROL_STATUS_DEFS_SVH
// configuration space offset of the power management control/status word
`define POWER_MGMT_CONTROL_STATUS_CFG_OFF 8'h44
// field positions inside the power management control/status word
`define POWER_MGMT_CONTROL_STATUS_STATE_LSB 0
`define POWER_MGMT_CONTROL_STATUS_STATE_MSB 1
`define POWER_MGMT_CONTROL_STATUS_WAKE_EN_BIT 8
`define POWER_MGMT_CONTROL_STATUS_WAKE_STS_BIT 15
`define POWER_MGMT_CONTROL_STATUS_RESET_VAL 32'h00000000
`define POWER_MGMT_CONTROL_STATUS_OP_RESET_VAL 32'h00000000
// operational register offsets
`define POWER_MGMT_CONTROL_STATUS_COMMAND_CONTROL 8'h00
`define POWER_MGMT_CONTROL_STATUS_DEVICE_CONFIGURATION 8'h04
`define POWER_MGMT_CONTROL_STATUS_EEPROM_ACCESS 8'h08
`define POWER_MGMT_CONTROL_STATUS_BUS_TEST_CONTROL 8'h0C
`define POWER_MGMT_CONTROL_STATUS_INTERRUPT_STATUS 8'h10
`define POWER_MGMT_CONTROL_STATUS_INTERRUPT_MASK 8'h14
`define POWER_MGMT_CONTROL_STATUS_INTERRUPT_ENABLE 8'h18
`define POWER_MGMT_CONTROL_STATUS_TX_DESCRIPTOR_POINTER 8'h20
`define POWER_MGMT_CONTROL_STATUS_TX_CONFIGURATION 8'h24
`define POWER_MGMT_CONTROL_STATUS_RX_DESCRIPTOR_POINTER 8'h30
`define POWER_MGMT_CONTROL_STATUS_RX_CONFIGURATION 8'h34
`define POWER_MGMT_CONTROL_STATUS_CLOCK_RUN_CONTROL 8'h3C
`define POWER_MGMT_CONTROL_STATUS_WAKE_LAN_CONTROL 8'h40
`define POWER_MGMT_CONTROL_STATUS_PAUSE_FLOW_CONTROL 8'h44
`define POWER_MGMT_CONTROL_STATUS_RX_FILTER_CONTROL 8'h48
`define POWER_MGMT_CONTROL_STATUS_RX_FILTER_DATA 8'h4C
`define POWER_MGMT_CONTROL_STATUS_BOOT_ROM_ADDRESS 8'h50
`define POWER_MGMT_CONTROL_STATUS_BOOT_ROM_DATA 8'h54
`define POWER_MGMT_CONTROL_STATUS_SILICON_REVISION 8'h58
`define POWER_MGMT_CONTROL_STATUS_STATISTICS_CONTROL 8'h5C
`define POWER_MGMT_CONTROL_STATUS_STATISTICS_FIRST 8'h60
`define POWER_MGMT_CONTROL_STATUS_STATISTICS_LAST 8'h78
`define POWER_MGMT_CONTROL_STATUS_PHY_BASIC_CONTROL 8'h80
`define POWER_MGMT_CONTROL_STATUS_PHY_BASIC_STATUS 8'h84
`define POWER_MGMT_CONTROL_STATUS_PHY_IDENTIFIER_HIGH 8'h88
`define POWER_MGMT_CONTROL_STATUS_PHY_IDENTIFIER_LOW 8'h8C
`define POWER_MGMT_CONTROL_STATUS_AUTONEG_ADVERTISEMENT 8'h90
`define POWER_MGMT_CONTROL_STATUS_AUTONEG_PARTNER_ABILITY 8'h94
`define POWER_MGMT_CONTROL_STATUS_AUTONEG_EXPANSION 8'h98
`define POWER_MGMT_CONTROL_STATUS_AUTONEG_NEXT_PAGE_TX 8'h9C
`define POWER_MGMT_CONTROL_STATUS_PHY_LINK_STATUS 8'hC0
`define POWER_MGMT_CONTROL_STATUS_PHY_IRQ_CONTROL 8'hC4
`define POWER_MGMT_CONTROL_STATUS_PHY_IRQ_STATUS 8'hC8
`define POWER_MGMT_CONTROL_STATUS_FALSE_CARRIER_COUNTER 8'hD0
`define POWER_MGMT_CONTROL_STATUS_RX_ERROR_COUNTER 8'hD4
`define POWER_MGMT_CONTROL_STATUS_FAST_PCS_CONFIG_STATUS 8'hD8
`define POWER_MGMT_CONTROL_STATUS_PHY_CONTROL 8'hE4
`define POWER_MGMT_CONTROL_STATUS_TEN_BASE_T_CONTROL_STATUS 8'hE8
// read answer latency in clock cycles
`define POWER_MGMT_CONTROL_STATUS_READ_LATENCY 1
`endif

// ===== hdl/power_mgmt_control_status_pkg.sv
// types shared by the power csr and register map block
package power_mgmt_control_status_pkg;
  // address space that a host access targets
  typedef enum logic [1:0] {
    POWER_MGMT_CONTROL_STATUS_SPACE_CFG = 2'h0,
    POWER_MGMT_CONTROL_STATUS_SPACE_MEM = 2'h1,
    POWER_MGMT_CONTROL_STATUS_SPACE_IO = 2'h3
  } power_mgmt_control_status_space_t;
  // power state encodings as stored in the field
  typedef enum logic [1:0] {
    POWER_MGMT_CONTROL_STATUS_D0 = 2'h0,
    POWER_MGMT_CONTROL_STATUS_D1 = 2'h1,
    POWER_MGMT_CONTROL_STATUS_D2 = 2'h2,
    POWER_MGMT_CONTROL_STATUS_D3 = 2'h3
  } power_mgmt_control_status_power_state_field_t;
  // one host access, valid for one cycle
  typedef struct packed {
    logic valid;
    logic write;
    power_mgmt_control_status_space_t space;
    logic [31:0] addr;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } power_mgmt_control_status_req_t;
  // read answer
  typedef struct packed {
    logic valid;
    logic [31:0] rdata;
  } power_mgmt_control_status_rsp_t;
endpackage

// ===== hdl/power_mgmt_control_status_regs.sv
// power management csr and operational register decode of the ethernet controller
//
// How it works
// - bridge, reserved and unused csr bits read zero
// - wake status is a sticky flag from events
// - wake status records even with wake disabled
// - enable set lets pending wake drive pin
// - enable clear holds wake pin inactive
// - enable bit can be preset from eeprom
// - power state coded 00 D0 to 11 D3
// - state reads current, writes request new state
// - hard reset clears whole csr to zero
// - operational set decoded in memory and io windows
// - writes to reserved offsets change nothing
// - reserved offset reads return don't-care value
// - statistics counters are read-only words 60h-78h
// - phy registers mapped from offset 80h onward
`include "power_mgmt_control_status_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module power_mgmt_control_status_regs
  import power_mgmt_control_status_pkg::*;
#(
  parameter logic [31:0] MEM_BASE = 32'h00001000,
  parameter logic [31:0] IO_BASE = 32'h00000100,
  parameter int STAT_WORDS = 7,
  // arbitrary neutral identity values
  parameter logic [31:0] SILICON_REV = 32'h00000001,
  parameter logic [31:0] PHY_ID_HIGH = 32'h00001234,
  parameter logic [31:0] PHY_ID_LOW = 32'h00005678
) (
  // clock and resets
  input wire logic clk,
  input wire logic rst,
  input wire logic soft_rst,
  // host access
  input wire power_mgmt_control_status_req_t host_req,
  output power_mgmt_control_status_rsp_t host_rsp,
  // wake logic and eeprom preset
  input wire logic wake_event,
  input wire logic eeprom_load,
  input wire logic eeprom_wake_en,
  // read-only state from the rest of the controller
  input wire logic [31:0] irq_status_in,
  input wire logic [31:0] phy_basic_status_in,
  input wire logic [31:0] phy_link_status_in,
  input wire logic [STAT_WORDS*32-1:0] stat_counters_in,
  // power and wake outputs
  output power_mgmt_control_status_power_state_field_t power_state,
  output logic wake_event_enable,
  output logic wake_event_status,
  output logic wake_output_n
);

  initial begin
    if (MEM_BASE[7:0] != 8'h00 || IO_BASE[7:0] != 8'h00) begin
      $error("window bases must be aligned to 256 bytes");
    end
    if (STAT_WORDS != 7) begin
      $error("statistics block spans exactly seven words");
    end
  end

  // operational offsets that hold software-writable storage
  function automatic logic is_rw(input logic [7:0] off);
    case (off)
      `POWER_MGMT_CONTROL_STATUS_COMMAND_CONTROL, `POWER_MGMT_CONTROL_STATUS_DEVICE_CONFIGURATION, `POWER_MGMT_CONTROL_STATUS_EEPROM_ACCESS,
      `POWER_MGMT_CONTROL_STATUS_BUS_TEST_CONTROL, `POWER_MGMT_CONTROL_STATUS_INTERRUPT_MASK, `POWER_MGMT_CONTROL_STATUS_INTERRUPT_ENABLE,
      `POWER_MGMT_CONTROL_STATUS_TX_DESCRIPTOR_POINTER, `POWER_MGMT_CONTROL_STATUS_TX_CONFIGURATION, `POWER_MGMT_CONTROL_STATUS_RX_DESCRIPTOR_POINTER,
      `POWER_MGMT_CONTROL_STATUS_RX_CONFIGURATION, `POWER_MGMT_CONTROL_STATUS_CLOCK_RUN_CONTROL, `POWER_MGMT_CONTROL_STATUS_WAKE_LAN_CONTROL,
      `POWER_MGMT_CONTROL_STATUS_PAUSE_FLOW_CONTROL, `POWER_MGMT_CONTROL_STATUS_RX_FILTER_CONTROL, `POWER_MGMT_CONTROL_STATUS_RX_FILTER_DATA,
      `POWER_MGMT_CONTROL_STATUS_BOOT_ROM_ADDRESS, `POWER_MGMT_CONTROL_STATUS_BOOT_ROM_DATA, `POWER_MGMT_CONTROL_STATUS_STATISTICS_CONTROL,
      `POWER_MGMT_CONTROL_STATUS_PHY_BASIC_CONTROL, `POWER_MGMT_CONTROL_STATUS_AUTONEG_ADVERTISEMENT, `POWER_MGMT_CONTROL_STATUS_AUTONEG_PARTNER_ABILITY,
      `POWER_MGMT_CONTROL_STATUS_AUTONEG_EXPANSION, `POWER_MGMT_CONTROL_STATUS_AUTONEG_NEXT_PAGE_TX, `POWER_MGMT_CONTROL_STATUS_PHY_IRQ_CONTROL,
      `POWER_MGMT_CONTROL_STATUS_PHY_IRQ_STATUS, `POWER_MGMT_CONTROL_STATUS_FALSE_CARRIER_COUNTER, `POWER_MGMT_CONTROL_STATUS_RX_ERROR_COUNTER,
      `POWER_MGMT_CONTROL_STATUS_FAST_PCS_CONFIG_STATUS, `POWER_MGMT_CONTROL_STATUS_PHY_CONTROL, `POWER_MGMT_CONTROL_STATUS_TEN_BASE_T_CONTROL_STATUS: begin
        is_rw = 1'b1;
      end
      default: begin
        is_rw = 1'b0;
      end
    endcase
  endfunction

  // byte-enable merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = res;
  endfunction

  // window decode: config, memory or io access
  logic [7:0] off;
  logic cfg_hit;
  logic op_hit;
  logic csr_wr;
  logic op_wr;
  assign off = {host_req.addr[7:2], 2'b00};
  assign cfg_hit = host_req.valid && host_req.space == POWER_MGMT_CONTROL_STATUS_SPACE_CFG && off == `POWER_MGMT_CONTROL_STATUS_CFG_OFF;
  assign op_hit = host_req.valid && ((host_req.space == POWER_MGMT_CONTROL_STATUS_SPACE_MEM &&
                  host_req.addr[31:8] == MEM_BASE[31:8]) || (host_req.space == POWER_MGMT_CONTROL_STATUS_SPACE_IO &&
                  host_req.addr[31:8] == IO_BASE[31:8]));
  assign csr_wr = cfg_hit && host_req.write;
  assign op_wr = op_hit && host_req.write && is_rw(off);

  // power state field: hard reset to D0, untouched by soft reset
  power_mgmt_control_status_power_state_field_t power_state_field_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      power_state_field_ff <= POWER_MGMT_CONTROL_STATUS_D0;
    end else if (csr_wr && host_req.byte_en[0]) begin
      power_state_field_ff <= power_mgmt_control_status_power_state_field_t'(host_req.wdata[`POWER_MGMT_CONTROL_STATUS_STATE_MSB:`POWER_MGMT_CONTROL_STATUS_STATE_LSB]);
    end
  end

  // wake enable: software write, eeprom preset; soft reset ignored
  logic wake_en_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_en_ff <= 1'b0;
    end else if (eeprom_load) begin
      wake_en_ff <= eeprom_wake_en;
    end else if (csr_wr && host_req.byte_en[1]) begin
      wake_en_ff <= host_req.wdata[`POWER_MGMT_CONTROL_STATUS_WAKE_EN_BIT];
    end
  end

  // sticky wake status, cleared by writing one; a new event beats the clear
  logic wake_sts_ff;
  logic sts_clr;
  assign sts_clr = csr_wr && host_req.byte_en[1] && host_req.wdata[`POWER_MGMT_CONTROL_STATUS_WAKE_STS_BIT];
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_sts_ff <= 1'b0;
    end else if (wake_event) begin
      wake_sts_ff <= 1'b1;
    end else if (sts_clr) begin
      wake_sts_ff <= 1'b0;
    end
  end
  // soft_rst deliberately reaches none of the three csr processes above

  // wake pin: registered, low the cycle after enable and a pending wake are both set
  logic wake_n_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_n_ff <= 1'b1;
    end else begin
      wake_n_ff <= ~(wake_en_ff & wake_sts_ff);
    end
  end

  // writable operational storage; soft reset restores it, unlike the csr
  logic [31:0] op_mem [0:63];
  always_ff @(posedge clk) begin
    if (rst || soft_rst) begin
      for (int i = 0; i < 64; i++) begin
        op_mem[i] <= `POWER_MGMT_CONTROL_STATUS_OP_RESET_VAL;
      end
    end else if (op_wr) begin
      op_mem[off[7:2]] <= merge(op_mem[off[7:2]], host_req.wdata, host_req.byte_en);
    end
  end

  // csr word as read: unused and reserved ranges are zero
  logic [31:0] csr_word;
  always_comb begin
    csr_word = `POWER_MGMT_CONTROL_STATUS_RESET_VAL;
    csr_word[`POWER_MGMT_CONTROL_STATUS_STATE_MSB:`POWER_MGMT_CONTROL_STATUS_STATE_LSB] = power_state_field_ff;
    csr_word[`POWER_MGMT_CONTROL_STATUS_WAKE_EN_BIT] = wake_en_ff;
    csr_word[`POWER_MGMT_CONTROL_STATUS_WAKE_STS_BIT] = wake_sts_ff;
  end

  // operational read mux; reserved offsets give zero, which software must not trust
  logic [31:0] op_word;
  logic [2:0] stat_idx;
  assign stat_idx = 3'(off[7:2] - 6'h18);
  always_comb begin
    op_word = 32'h00000000;
    if (is_rw(off)) begin
      op_word = op_mem[off[7:2]];
    end else if (off >= `POWER_MGMT_CONTROL_STATUS_STATISTICS_FIRST && off <= `POWER_MGMT_CONTROL_STATUS_STATISTICS_LAST) begin
      op_word = stat_counters_in[stat_idx*32 +: 32];
    end else begin
      case (off)
        `POWER_MGMT_CONTROL_STATUS_INTERRUPT_STATUS: begin
          op_word = irq_status_in;
        end
        `POWER_MGMT_CONTROL_STATUS_SILICON_REVISION: begin
          op_word = SILICON_REV;
        end
        `POWER_MGMT_CONTROL_STATUS_PHY_BASIC_STATUS: begin
          op_word = phy_basic_status_in;
        end
        `POWER_MGMT_CONTROL_STATUS_PHY_IDENTIFIER_HIGH: begin
          op_word = PHY_ID_HIGH;
        end
        `POWER_MGMT_CONTROL_STATUS_PHY_IDENTIFIER_LOW: begin
          op_word = PHY_ID_LOW;
        end
        `POWER_MGMT_CONTROL_STATUS_PHY_LINK_STATUS: begin
          op_word = phy_link_status_in;
        end
        default: begin
          op_word = 32'h00000000;
        end
      endcase
    end
  end

  // read answer one cycle after the request; misses answer zero so the host never hangs
  power_mgmt_control_status_rsp_t rsp_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff.valid <= host_req.valid && !host_req.write;
      rsp_ff.rdata <= cfg_hit ? csr_word : (op_hit ? op_word : 32'h00000000);
    end
  end

  assign host_rsp = rsp_ff;
  assign power_state = power_state_field_ff;
  assign wake_event_enable = wake_en_ff;
  assign wake_event_status = wake_sts_ff;
  assign wake_output_n = wake_n_ff;

  // checks
  sequence wake_pending_s;
    wake_en_ff && wake_sts_ff;
  endsequence

  csr_zero_bits_a: assert property (@(posedge clk) disable iff (rst)
    rsp_ff.valid && $past(cfg_hit) |-> rsp_ff.rdata[31:16] == 16'h0000 && rsp_ff.rdata[14:9] == 6'h00
    && rsp_ff.rdata[7:2] == 6'h00)
    else $error("reserved csr bits read nonzero");

  sts_sticky_a: assert property (@(posedge clk) disable iff (rst)
    wake_sts_ff && !sts_clr |=> wake_sts_ff)
    else $error("wake status dropped without a clear");

  sts_sets_a: assert property (@(posedge clk) disable iff (rst)
    wake_event |=> wake_sts_ff)
    else $error("wake event not recorded");

  pin_assert_a: assert property (@(posedge clk) disable iff (rst)
    wake_pending_s ##1 wake_pending_s |-> !wake_output_n)
    else $error("wake pin not driven while pending");

  pin_quiet_a: assert property (@(posedge clk) disable iff (rst)
    $past(!wake_en_ff) |-> wake_output_n)
    else $error("wake pin active while disabled");

  eeprom_preset_a: assert property (@(posedge clk) disable iff (rst)
    eeprom_load |=> wake_en_ff == $past(eeprom_wake_en))
    else $error("eeprom preset of wake enable lost");

  state_write_a: assert property (@(posedge clk) disable iff (rst)
    csr_wr && host_req.byte_en[0] |=> power_state_field_ff == $past(host_req.wdata[1:0]))
    else $error("power state write not taken");

  hard_reset_a: assert property (@(posedge clk)
    rst |=> power_state_field_ff == POWER_MGMT_CONTROL_STATUS_D0 && !wake_en_ff && !wake_sts_ff && wake_output_n)
    else $error("csr not cleared by hard reset");

  reserved_write_a: assert property (@(posedge clk) disable iff (rst || soft_rst)
    host_req.valid && host_req.write && !is_rw(off) && !cfg_hit |=> op_mem[$past(off[7:2])] ==
    $past(op_mem[off[7:2]]))
    else $error("reserved offset write changed storage");

  soft_keep_a: assert property (@(posedge clk) disable iff (rst)
    soft_rst && !host_req.valid && !eeprom_load && !wake_event |=> $stable(csr_word))
    else $error("soft reset disturbed the csr");

  // read checks below compare the registered answer against the state sampled at the taking edge;
  // each target window gets its own named sequence so the properties stay one line long
  sequence read_taken_s;
    host_req.valid && !host_req.write;
  endsequence

  sequence cfg_read_s;
    host_req.valid && !host_req.write && cfg_hit;
  endsequence

  sequence stat_read_s;
    host_req.valid && !host_req.write && op_hit && off >= `POWER_MGMT_CONTROL_STATUS_STATISTICS_FIRST && off <= `POWER_MGMT_CONTROL_STATUS_STATISTICS_LAST;
  endsequence

  sequence phy_ctrl_read_s;
    host_req.valid && !host_req.write && op_hit && off == `POWER_MGMT_CONTROL_STATUS_PHY_BASIC_CONTROL;
  endsequence

  sequence miss_read_s;
    host_req.valid && !host_req.write && !cfg_hit && !op_hit;
  endsequence

  // an event followed by a cycle with enable and status both set
  sequence wake_raised_s;
    wake_event ##1 wake_pending_s;
  endsequence

  // every read gets exactly one answer, one cycle later
  read_answer_a: assert property (@(posedge clk) disable iff (rst)
    read_taken_s |=> rsp_ff.valid)
    else $error("read answer missing");

  // writes never produce an answer, reserved or not
  write_silent_a: assert property (@(posedge clk) disable iff (rst)
    host_req.valid && host_req.write |=> !rsp_ff.valid)
    else $error("write produced a read answer");

  // the state field reads back the current state, not a pending request
  csr_state_read_a: assert property (@(posedge clk) disable iff (rst)
    cfg_read_s |=> rsp_ff.rdata[1:0] == $past(power_state_field_ff))
    else $error("power state read wrong");

  // status and enable read back from their own flops
  csr_flags_read_a: assert property (@(posedge clk) disable iff (rst)
    cfg_read_s |=> rsp_ff.rdata[15] == $past(wake_sts_ff) && rsp_ff.rdata[8] == $past(wake_en_ff))
    else $error("wake flags read wrong");

  // statistics words come straight from the counter inputs
  stat_read_a: assert property (@(posedge clk) disable iff (rst)
    stat_read_s |=> rsp_ff.rdata == $past(stat_counters_in[stat_idx*32 +: 32]))
    else $error("statistics word read wrong");

  // first phy word lives at 80h of the operational space
  phy_read_a: assert property (@(posedge clk) disable iff (rst)
    phy_ctrl_read_s |=> rsp_ff.rdata == $past(op_mem[6'h20]))
    else $error("phy control word read wrong");

  // misses answer zero so a stray read never shows stale data
  miss_zero_a: assert property (@(posedge clk) disable iff (rst)
    miss_read_s |=> rsp_ff.rdata == 32'h00000000)
    else $error("missed read answered nonzero");

  // a write in either window lands with its byte lanes merged
  op_write_a: assert property (@(posedge clk) disable iff (rst || soft_rst)
    op_wr |=> op_mem[$past(off[7:2])] == $past(merge(op_mem[off[7:2]], host_req.wdata, host_req.byte_en)))
    else $error("operational write not stored");

  // pending wake with enable set drives the pin one cycle later
  pin_follow_a: assert property (@(posedge clk) disable iff (rst)
    wake_raised_s |=> !wake_output_n)
    else $error("wake pin late after event");

  // a software write of the enable lands unless the eeprom preset wins
  enable_write_a: assert property (@(posedge clk) disable iff (rst)
    csr_wr && host_req.byte_en[1] && !eeprom_load |=> wake_en_ff == $past(host_req.wdata[`POWER_MGMT_CONTROL_STATUS_WAKE_EN_BIT]))
    else $error("wake enable write not taken");

  // a clear with no competing event empties the status
  sts_clear_a: assert property (@(posedge clk) disable iff (rst)
    sts_clr && !wake_event |=> !wake_sts_ff)
    else $error("wake status not cleared");

  // status never rises on its own
  sts_quiet_a: assert property (@(posedge clk) disable iff (rst)
    !wake_sts_ff && !wake_event |=> !wake_sts_ff)
    else $error("wake status rose without an event");

  // state only moves on a lane-0 csr write
  state_hold_a: assert property (@(posedge clk) disable iff (rst)
    !(csr_wr && host_req.byte_en[0]) |=> $stable(power_state_field_ff))
    else $error("power state moved without a write");

  // soft reset empties the operational storage while the csr is kept
  soft_op_clear_a: assert property (@(posedge clk) disable iff (rst)
    soft_rst |=> op_mem[0] == `POWER_MGMT_CONTROL_STATUS_OP_RESET_VAL)
    else $error("soft reset left operational storage");

endmodule
`default_nettype wire

// ===== verif/power_mgmt_control_status_host_model.sv
// host bridge model that issues single configuration, memory and io accesses
`timescale 1ns/100ps
`default_nettype none
module power_mgmt_control_status_host_model
  import power_mgmt_control_status_pkg::*;
(
  // clock
  input wire logic clk,
  // request out, answer in
  output power_mgmt_control_status_req_t req,
  input wire power_mgmt_control_status_rsp_t rsp
);
  initial req = '0;

  // one access per call, launched just after an edge and held through the taking edge
  task automatic access(input logic w, input power_mgmt_control_status_space_t sp, input logic [31:0] a, input logic [3:0] be,
                        input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    #1;
    // a write of the state field is how software asks for a new power state
    req = '{valid: 1'b1, write: w, space: sp, addr: a, byte_en: be, wdata: d};
    @(posedge clk);
    #1;
    // valid dropped, address and data inverted once released so a stale address never looks current
    req.valid = 1'b0;
    req.addr = ~a;
    req.wdata = ~d;
    // answer from a reserved offset is handed back but callers never trust it
    q = rsp.rdata;
    if (!w && rsp.valid !== 1'b1) begin
      q = 32'hXXXXXXXX;
    end
  endtask
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// self-checking bench for the power csr and operational register map
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import power_mgmt_control_status_pkg::*;
  localparam logic [31:0] MEM_B = 32'h00001000;
  localparam logic [31:0] IO_B = 32'h00000100;
  logic clk, rst, soft_rst, wake_event, eeprom_load, eeprom_wake_en, wake_event_enable, wake_event_status;
  logic wake_output_n;
  logic [31:0] irq_status_in, phy_basic_status_in, phy_link_status_in, rd, d;
  logic [223:0] stat_counters_in;
  power_mgmt_control_status_req_t host_req;
  power_mgmt_control_status_rsp_t host_rsp;
  power_mgmt_control_status_power_state_field_t power_state;
  int errors, checked, cycles, seed;

  power_mgmt_control_status_regs #(.MEM_BASE(MEM_B), .IO_BASE(IO_B), .STAT_WORDS(7)) power_mgmt_control_status_regs_i (
    .clk(clk), .rst(rst), .soft_rst(soft_rst), .host_req(host_req), .host_rsp(host_rsp),
    .wake_event(wake_event), .eeprom_load(eeprom_load), .eeprom_wake_en(eeprom_wake_en),
    .irq_status_in(irq_status_in), .phy_basic_status_in(phy_basic_status_in),
    .phy_link_status_in(phy_link_status_in), .stat_counters_in(stat_counters_in),
    .power_state(power_state), .wake_event_enable(wake_event_enable),
    .wake_event_status(wake_event_status), .wake_output_n(wake_output_n));

  power_mgmt_control_status_host_model power_mgmt_control_status_host_model_i (.clk(clk), .req(host_req), .rsp(host_rsp));

  // free-running 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic finish_test;
    if (errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // expected csr word: only status, enable and state may ever read non-zero
  function automatic logic [31:0] csr_exp(input logic sts, input logic en, input logic [1:0] st);
    return {16'h0000, sts, 6'h00, en, 6'h00, st};
  endfunction

  task automatic cfg_wr(input logic [3:0] be, input logic [31:0] v);
    power_mgmt_control_status_host_model_i.access(1'b1, POWER_MGMT_CONTROL_STATUS_SPACE_CFG, 32'h00000044, be, v, rd);
  endtask

  task automatic cfg_chk(input logic [31:0] exp);
    power_mgmt_control_status_host_model_i.access(1'b0, POWER_MGMT_CONTROL_STATUS_SPACE_CFG, 32'h00000044, 4'hF, 32'h00000000, rd);
    check(rd, exp);
  endtask

  task automatic op(input logic w, input power_mgmt_control_status_space_t sp, input logic [7:0] off, input logic [31:0] v);
    power_mgmt_control_status_host_model_i.access(w, sp, (sp == POWER_MGMT_CONTROL_STATUS_SPACE_IO ? IO_B : MEM_B) | {24'h000000, off}, 4'hF, v, rd);
  endtask

  task automatic pulse_wake;
    wake_event = 1'b1;
    tick(1);
    wake_event = 1'b0;
    tick(3);
  endtask

  initial begin
    seed = 77416;
    errors = 0;
    checked = 0;
    cycles = 0;
    rst = 1'b1;
    soft_rst = 1'b0;
    wake_event = 1'b0;
    eeprom_load = 1'b0;
    eeprom_wake_en = 1'b0;
    irq_status_in = $random(seed);
    phy_basic_status_in = $random(seed);
    phy_link_status_in = $random(seed);
    for (int k = 0; k < 7; k++) begin
      stat_counters_in[k*32 +: 32] = $random(seed);
    end
    tick(6);
    rst = 1'b0;
    cfg_chk(32'h00000000);
    check({31'h0, wake_output_n}, 32'h1);
    // every state code through lane 0, with random junk in the unused bits
    for (int s = 0; s < 4; s++) begin
      cfg_wr(4'h1, ($random(seed) & 32'hFFFFFFFC) | s);
      cfg_chk(csr_exp(1'b0, 1'b0, s[1:0]));
      check({30'h0, power_state}, {30'h0, s[1:0]});
    end
    cfg_wr(4'hF, 32'hFFFFFFFF);
    cfg_chk(csr_exp(1'b0, 1'b1, 2'h3));
    pulse_wake();
    check({31'h0, wake_output_n}, 32'h0);
    check({31'h0, wake_event_status}, 32'h1);
    cfg_wr(4'h2, 32'h00000000);
    tick(2);
    check({31'h0, wake_output_n}, 32'h1);
    check({31'h0, wake_event_enable}, 32'h0);
    cfg_chk(csr_exp(1'b1, 1'b0, 2'h3));
    cfg_wr(4'h2, 32'h00008000);
    cfg_chk(csr_exp(1'b0, 1'b0, 2'h3));
    // event with the pin disabled still lands in status
    pulse_wake();
    check({31'h0, wake_output_n}, 32'h1);
    cfg_chk(csr_exp(1'b1, 1'b0, 2'h3));
    eeprom_wake_en = 1'b1;
    eeprom_load = 1'b1;
    tick(1);
    eeprom_load = 1'b0;
    tick(2);
    check({31'h0, wake_output_n}, 32'h0);
    check({31'h0, wake_event_enable}, 32'h1);
    cfg_chk(csr_exp(1'b1, 1'b1, 2'h3));
    soft_rst = 1'b1;
    tick(1);
    soft_rst = 1'b0;
    cfg_chk(csr_exp(1'b1, 1'b1, 2'h3));
    // operational space: random data through both windows, with writes to reserved and read-only places
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      op(1'b1, POWER_MGMT_CONTROL_STATUS_SPACE_MEM, 8'h00, d);
      op(1'b0, POWER_MGMT_CONTROL_STATUS_SPACE_IO, 8'h00, 32'h0);
      check(rd, d);
      op(1'b1, POWER_MGMT_CONTROL_STATUS_SPACE_IO, 8'h1C, ~d);
      op(1'b1, POWER_MGMT_CONTROL_STATUS_SPACE_MEM, 8'h60 + 8'(i * 4), ~d);
      op(1'b0, POWER_MGMT_CONTROL_STATUS_SPACE_MEM, 8'h00, 32'h0);
      check(rd, d);
      op(1'b1, POWER_MGMT_CONTROL_STATUS_SPACE_IO, 8'h80, ~d);
      op(1'b0, POWER_MGMT_CONTROL_STATUS_SPACE_MEM, 8'h80, 32'h0);
      check(rd, ~d);
    end
    for (int k = 0; k < 7; k++) begin
      op(1'b0, k[0] ? POWER_MGMT_CONTROL_STATUS_SPACE_IO : POWER_MGMT_CONTROL_STATUS_SPACE_MEM, 8'h60 + 8'(k * 4), 32'h0);
      check(rd, stat_counters_in[k*32 +: 32]);
    end
    op(1'b0, POWER_MGMT_CONTROL_STATUS_SPACE_MEM, 8'h84, 32'h0);
    check(rd, phy_basic_status_in);
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    cfg_chk(32'h00000000);
    check({31'h0, wake_output_n}, 32'h1);
    finish_test();
  end
endmodule
`default_nettype wire
